/* np_gig_pkg.sv */
// package: offsets, field positions, reset values and modes of the page/gigabit registers
package np_gig_pkg;
	// ****************************************
	// register map (byte addresses, index*4)
	// ****************************************
	localparam logic [7:0] IDX_RX_PAGE = 8'h08; // received next page index
	localparam logic [7:0] IDX_GIG_CTRL = 8'h09; // gigabit control index
	localparam logic [9:0] ADR_RX_PAGE = {IDX_RX_PAGE, 2'b00}; // byte address of received page
	localparam logic [9:0] ADR_GIG_CTRL = {IDX_GIG_CTRL, 2'b00}; // byte address of gig control
	// ****************************************
	// received next page fields
	// ****************************************
	localparam int BIT_MORE_PAGES = 15; // more pages flag
	localparam int BIT_ACK = 14; // acknowledge
	localparam int BIT_MSG_PAGE = 13; // message page flag
	localparam int BIT_COMPLY = 12; // comply with message flag
	localparam int BIT_TOGGLE = 11; // received toggle flag
	localparam int CODE_MSB = 10; // code field top bit
	localparam logic [15:0] RX_PAGE_RESET = 16'h0000; // all fields clear after reset
	// ****************************************
	// gigabit control fields
	// ****************************************
	localparam int TEST_LSB = 13; // test mode select low bit
	localparam int BIT_MANUAL_EN = 12; // manual master/slave enable
	localparam int BIT_MANUAL_VAL = 11; // manual role value
	localparam int BIT_REPEATER = 10; // repeater/switch advertisement
	localparam logic [15:0] GIG_WRITE_MASK = 16'hFC00; // writable bits, low bits read zero
	typedef enum logic [2:0] {
		TM_NORMAL = 3'b000,
		TM_ONE = 3'b001,
		TM_TWO = 3'b010,
		TM_THREE = 3'b011,
		TM_FOUR = 3'b100
	} test_mode_e;
	typedef enum logic [1:0] {
		ROLE_AUTO = 2'b00,
		ROLE_SLAVE = 2'b01,
		ROLE_MASTER = 2'b10
	} role_e;
endpackage : np_gig_pkg

/* autoneg_next_page_rx_and_gig_control.sv */
// received next page and gigabit control register bank on classic wishbone
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
// Function
// - capture partner next page into register 0x08
// - toggle flag inverts prior exchanged toggle
// - code field bits 10:0, read only
// - code field reads zero after reset
// - test mode field selects normal or 1..4
// - bit 12 selects manual role configuration
// - bit 11 forces master/slave when manual
// - bit 10 advertisement, reset from strap when autoneg enabled, else zero
// - report flags at bits 15..12, reset zero
module autoneg_next_page_rx_and_gig_control (
	input wire logic mclk, // 100 MHz clock
	input wire logic rst, // async reset, active high
	input wire logic wbCyc, // wishbone cycle
	input wire logic wbStb, // wishbone strobe
	input wire logic wbWe, // write enable
	input wire logic [3:0] wbSel, // byte selects
	input wire logic [9:0] wbAdr, // byte address
	input wire logic [31:0] wbDatI, // write data
	output logic [31:0] wbDatO, // read data, registered
	output logic wbAck, // acknowledge
	output logic wbErr, // error for unmapped address
	input wire logic pageValid, // one-cycle pulse: partner page word received
	input wire logic [15:0] pageWord, // received link code word
	input wire logic autonegEnable, // auto-negotiation enabled, sampled at reset release
	input wire logic repeaterStrap, // device type strap, sampled at reset release
	output logic [2:0] testMode, // selected test mode
	output logic [1:0] roleSelect, // role: auto, slave or master
	output logic repeaterAdvert // advertise repeater/switch
);
	// ****************************************
	// state
	// ****************************************
	logic [15:0] rxPage; // captured partner page
	logic [15:0] next_rxPage; // next captured page
	logic [15:0] gigCtrl; // gigabit control bits 15:10
	logic [15:0] next_gigCtrl; // next control value
	logic strapDone; // strap already sampled since reset
	logic next_strapDone; // next strap flag
	logic [31:0] next_wbDatO; // next read data
	logic next_wbAck; // next ack
	logic next_wbErr; // next error
	logic busReq; // request pending, not yet answered
	logic hitPage; // address hits received page
	logic hitCtrl; // address hits control
	logic [15:0] laneMask; // byte enable mask for low half

	// ****************************************
	// bus decode
	// ****************************************
	// low half byte enables to a 16-bit mask
	function automatic logic [15:0] sel_mask(input logic [3:0] sel);
		sel_mask = {{8{sel[1]}}, {8{sel[0]}}};
	endfunction : sel_mask

	// held off until the strap is in, so a write is never acked and then lost
	assign busReq = wbCyc && wbStb && !wbAck && !wbErr && strapDone;
	assign hitPage = (wbAdr == np_gig_pkg::ADR_RX_PAGE);
	assign hitCtrl = (wbAdr == np_gig_pkg::ADR_GIG_CTRL);
	assign laneMask = sel_mask(wbSel);

	// ****************************************
	// received page capture
	// ****************************************
	// capture partner word; toggle stored inverted, bus writes never touch it
	always_comb begin
		next_rxPage = rxPage;
		if (pageValid) begin
			next_rxPage = pageWord;
			next_rxPage[np_gig_pkg::BIT_TOGGLE] = ~pageWord[np_gig_pkg::BIT_TOGGLE];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rxPage <= np_gig_pkg::RX_PAGE_RESET;
		end else begin
			rxPage <= next_rxPage;
		end
	end

	// ****************************************
	// gigabit control register
	// ****************************************
	// strap taken in the first cycle after release, then bus writes
	always_comb begin
		next_gigCtrl = gigCtrl;
		next_strapDone = 1'b1;
		if (!strapDone) begin
			next_gigCtrl[np_gig_pkg::BIT_REPEATER] = autonegEnable && repeaterStrap;
		end else if (busReq && wbWe && hitCtrl) begin
			next_gigCtrl = ((gigCtrl & ~laneMask) | (wbDatI[15:0] & laneMask))
				& np_gig_pkg::GIG_WRITE_MASK;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gigCtrl <= 16'h0000;
			strapDone <= 1'b0;
		end else begin
			gigCtrl <= next_gigCtrl;
			strapDone <= next_strapDone;
		end
	end

	// ****************************************
	// control outputs
	// ****************************************
	assign testMode = gigCtrl[np_gig_pkg::TEST_LSB +: 3];
	assign repeaterAdvert = gigCtrl[np_gig_pkg::BIT_REPEATER];
	// role only forced while manual enable set
	always_comb begin
		if (!gigCtrl[np_gig_pkg::BIT_MANUAL_EN]) begin
			roleSelect = np_gig_pkg::ROLE_AUTO;
		end else if (gigCtrl[np_gig_pkg::BIT_MANUAL_VAL]) begin
			roleSelect = np_gig_pkg::ROLE_MASTER;
		end else begin
			roleSelect = np_gig_pkg::ROLE_SLAVE;
		end
	end

	// ****************************************
	// bus answer
	// ****************************************
	// one-cycle answer; writes to the page register acked and dropped
	always_comb begin
		next_wbAck = 1'b0;
		next_wbErr = 1'b0;
		next_wbDatO = wbDatO;
		if (busReq) begin
			if (hitPage) begin
				next_wbAck = 1'b1;
				if (!wbWe) begin
					next_wbDatO = {16'h0000, rxPage};
				end
			end else if (hitCtrl) begin
				next_wbAck = 1'b1;
				if (!wbWe) begin
					next_wbDatO = {16'h0000, gigCtrl};
				end
			end else begin
				next_wbErr = 1'b1; // unmapped
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wbAck <= 1'b0;
			wbErr <= 1'b0;
			wbDatO <= 32'h00000000;
		end else begin
			wbAck <= next_wbAck;
			wbErr <= next_wbErr;
			wbDatO <= next_wbDatO;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	// checks stay off while reset is high, except those on reset values

	property p_capture;
		@(posedge mclk) disable iff (rst)
		pageValid |=> (rxPage[15:12] == $past(pageWord[15:12]))
			&& (rxPage[np_gig_pkg::CODE_MSB:0] == $past(pageWord[10:0]));
	endproperty
	a_capture: assert property (p_capture) else $error("page not captured");

	property p_toggle;
		@(posedge mclk) disable iff (rst)
		pageValid |=> rxPage[np_gig_pkg::BIT_TOGGLE] != $past(pageWord[np_gig_pkg::BIT_TOGGLE]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle not inverted");

	property p_hold;
		@(posedge mclk) disable iff (rst)
		!pageValid |=> $stable(rxPage);
	endproperty
	a_hold: assert property (p_hold) else $error("page changed without capture");

	property p_reset_zero;
		@(posedge mclk)
		$fell(rst) |-> rxPage == 16'h0000;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("page not zero after reset");

	property p_testmode;
		@(posedge mclk) disable iff (rst)
		(busReq && wbWe && hitCtrl && strapDone && wbSel[1]) |=>
			testMode == $past(wbDatI[15:13]);
	endproperty
	a_testmode: assert property (p_testmode) else $error("test mode not written");

	property p_auto;
		@(posedge mclk) disable iff (rst)
		!gigCtrl[np_gig_pkg::BIT_MANUAL_EN] |-> roleSelect == np_gig_pkg::ROLE_AUTO;
	endproperty
	a_auto: assert property (p_auto) else $error("role forced while automatic");

	property p_manual;
		@(posedge mclk) disable iff (rst)
		gigCtrl[np_gig_pkg::BIT_MANUAL_EN] |->
			roleSelect == (gigCtrl[np_gig_pkg::BIT_MANUAL_VAL] ? 2'h2 : 2'h1);
	endproperty
	a_manual: assert property (p_manual) else $error("manual role wrong");

	property p_strap;
		@(posedge mclk) disable iff (rst)
		!strapDone |=> repeaterAdvert == ($past(autonegEnable) && $past(repeaterStrap));
	endproperty
	a_strap: assert property (p_strap) else $error("strap not taken");

	property p_ro_write;
		@(posedge mclk) disable iff (rst)
		(busReq && wbWe && hitPage && !pageValid) |=> $stable(rxPage) && wbAck;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("page register written");

	property p_flags;
		@(posedge mclk) disable iff (rst)
		(busReq && !wbWe && hitPage) |=> wbDatO[15:12] == $past(rxPage[15:12]);
	endproperty
	a_flags: assert property (p_flags) else $error("flags misread");

	// answer to a mapped request comes at the very next edge
	property p_ack_next;
		@(posedge mclk) disable iff (rst)
		(busReq && (hitPage || hitCtrl)) |=> wbAck && !wbErr;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("mapped request not acked");

	// ack is a single-cycle pulse
	property p_ack_pulse;
		@(posedge mclk) disable iff (rst)
		wbAck |=> !wbAck;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack stuck high");

	// unmapped request answered by error alone
	property p_err_unmapped;
		@(posedge mclk) disable iff (rst)
		(busReq && !hitPage && !hitCtrl) |=> wbErr && !wbAck;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");

	// no answer while the strap load is pending
	property p_strap_wait;
		@(posedge mclk) disable iff (rst)
		!strapDone |=> !wbAck && !wbErr;
	endproperty
	a_strap_wait: assert property (p_strap_wait) else $error("answer before strap load");

	// reset leaves normal test mode and automatic role
	property p_reset_ctrl;
		@(posedge mclk)
		$fell(rst) |-> (testMode == np_gig_pkg::TM_NORMAL)
			&& (roleSelect == np_gig_pkg::ROLE_AUTO);
	endproperty
	a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not normal");

	// control holds unless written or strap loading
	property p_ctrl_hold;
		@(posedge mclk) disable iff (rst)
		(strapDone && !(busReq && wbWe && hitCtrl)) |=> $stable(gigCtrl);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unasked");

	// manual enable and value follow the high lane
	property p_role_write;
		@(posedge mclk) disable iff (rst)
		(busReq && wbWe && hitCtrl && wbSel[1]) |=>
			gigCtrl[12:11] == $past(wbDatI[12:11]);
	endproperty
	a_role_write: assert property (p_role_write) else $error("role bits not written");

	// advertisement bit follows the high lane
	property p_repeater_write;
		@(posedge mclk) disable iff (rst)
		(busReq && wbWe && hitCtrl && wbSel[1]) |=> repeaterAdvert == $past(wbDatI[10]);
	endproperty
	a_repeater_write: assert property (p_repeater_write) else $error("advert not written");

	// control read shows bits 15:10, zeros below
	property p_ctrl_read;
		@(posedge mclk) disable iff (rst)
		(busReq && !wbWe && hitCtrl) |=> wbDatO[15:0] == {$past(gigCtrl[15:10]), 10'h000};
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control misread");

	// code field read back unaltered
	property p_code_read;
		@(posedge mclk) disable iff (rst)
		(busReq && !wbWe && hitPage) |=> wbDatO[10:0] == $past(rxPage[10:0]);
	endproperty
	a_code_read: assert property (p_code_read) else $error("code field misread");

	// upper half of read data always zero
	property p_upper_zero;
		@(posedge mclk) disable iff (rst)
		wbAck |-> wbDatO[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read data not zero");
endmodule : autoneg_next_page_rx_and_gig_control

/* page_partner.sv */
// link partner model that hands received page words to the block
`timescale 1ns/1ps
module page_partner (
	input wire logic mclk, // clock
	input wire logic sendReq, // send one word this cycle
	input wire logic [15:0] sendWord, // word to send
	output logic pageValid, // one-cycle word strobe
	output logic [15:0] pageWord // word, scrambled when idle
);
	// idle lines keep moving so a stale word never looks valid
	initial pageWord = 16'hA5C3;
	// one strobe per word; the block must capture it
	always @(posedge mclk) begin
		pageValid <= sendReq;
		pageWord <= sendReq ? sendWord : ~pageWord;
	end
endmodule : page_partner

/* autoneg_next_page_rx_and_gig_control_bench.sv */
// self-checking bench for the page and gigabit control registers
`timescale 1ns/1ps
module autoneg_next_page_rx_and_gig_control_bench;
	// ****************************************
	// signals and models
	// ****************************************
	logic mclk = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, sendReq = 0;
	logic autonegEnable = 1, repeaterStrap = 1, wbAck, wbErr, pageValid, repeaterAdvert;
	logic [3:0] wbSel = 4'h0;
	logic [9:0] wbAdr = 10'h000;
	logic [31:0] wbDatI = 32'h0, wbDatO, seed = 32'hDA0BDE62, r;
	logic [15:0] pageWord, sendWord = 16'h0000, exp, w;
	logic [2:0] testMode;
	logic [1:0] roleSelect;
	logic [17:0] notes[$]; // expected answers: read flag, err, data
	logic [17:0] n;
	int miscompares = 0, n_tests = 0, cycles = 0;
	always #5 mclk = ~mclk;
	autoneg_next_page_rx_and_gig_control DUT (.mclk(mclk), .rst(rst), .wbCyc(wbCyc),
		.wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr), .wbDatI(wbDatI),
		.wbDatO(wbDatO), .wbAck(wbAck), .wbErr(wbErr), .pageValid(pageValid),
		.pageWord(pageWord), .autonegEnable(autonegEnable), .repeaterStrap(repeaterStrap),
		.testMode(testMode), .roleSelect(roleSelect), .repeaterAdvert(repeaterAdvert));
	page_partner partner (.mclk(mclk), .sendReq(sendReq), .sendWord(sendWord),
		.pageValid(pageValid), .pageWord(pageWord));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic check(input logic [15:0] got, input logic [15:0] want);
		n_tests++;
		if (got !== want) begin
			miscompares++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask : check
	task automatic give_verdict();
		if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	// one classic cycle, held until ack or err is sampled
	task automatic bus(input logic we, input logic [9:0] a, input logic [3:0] s,
		input logic [15:0] d, input logic [17:0] note);
		notes.push_back(note);
		@(posedge mclk);
		wbCyc <= 1;
		wbStb <= 1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= s;
		wbDatI <= {16'hFFFF, d};
		do @(posedge mclk); while (wbAck !== 1'b1 && wbErr !== 1'b1);
		wbCyc <= 0;
		wbStb <= 0;
	endtask : bus
	task automatic rd(input logic [9:0] a, input logic e, input logic [15:0] d);
		bus(0, a, 4'h3, 16'h0000, {~e, e, d});
	endtask : rd
	task automatic wr(input logic [9:0] a, input logic [3:0] s, input logic [15:0] d, input logic e);
		bus(1, a, s, d, {1'b0, e, 16'h0000});
	endtask : wr
	task automatic do_reset(input logic an);
		autonegEnable <= an;
		rst <= 1;
		repeat (12) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
	endtask : do_reset
	// monitor: compare each answer with the oldest note, and cut hangs short
	always @(posedge mclk) begin
		cycles++;
		if (cycles > 4000) begin
			miscompares++;
			give_verdict();
		end else if (wbAck === 1'b1 || wbErr === 1'b1) begin
			n = notes.pop_front();
			check({15'h0, wbErr}, {15'h0, n[16]});
			if (n[17]) check(wbDatO[15:0], n[15:0]);
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		for (int a = 0; a < 2; a++) begin
			do_reset(a[0]);
			rd(np_gig_pkg::ADR_RX_PAGE, 0, 16'h0000);
			rd(np_gig_pkg::ADR_GIG_CTRL, 0, {5'h00, a[0], 10'h000});
			check({15'h0, repeaterAdvert}, {15'h0, a[0]});
		end
		// two pages back to back, the later one must stand
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			exp = r[15:0];
			@(posedge mclk);
			sendReq <= 1;
			sendWord <= ~exp;
			@(posedge mclk);
			sendWord <= exp;
			@(posedge mclk);
			sendReq <= 0;
			rd(np_gig_pkg::ADR_RX_PAGE, 0, exp ^ 16'h0800);
			wr(np_gig_pkg::ADR_RX_PAGE, 4'h3, ~exp, 0);
			rd(np_gig_pkg::ADR_RX_PAGE, 0, exp ^ 16'h0800);
		end
		// every test mode with every manual role setting
		for (int m = 0; m < 5; m++) for (int j = 0; j < 4; j++) begin
			r = rnd();
			w = {m[2:0], j[1], j[0], r[10:0]};
			wr(np_gig_pkg::ADR_GIG_CTRL, 4'h3, w, 0);
			rd(np_gig_pkg::ADR_GIG_CTRL, 0, w & np_gig_pkg::GIG_WRITE_MASK);
			check({13'h0, testMode}, {13'h0, m[2:0]});
			check({14'h0, roleSelect}, {14'h0, j[1] ? (j[0] ? np_gig_pkg::ROLE_MASTER :
				np_gig_pkg::ROLE_SLAVE) : np_gig_pkg::ROLE_AUTO});
			check({15'h0, repeaterAdvert}, {15'h0, r[10]});
		end
		// low lane only, then unmapped places: nothing may change
		wr(np_gig_pkg::ADR_GIG_CTRL, 4'h1, 16'hFFFF, 0);
		rd(10'h030, 1, 16'h0000);
		wr(10'h3FC, 4'h3, 16'h0000, 1);
		rd(np_gig_pkg::ADR_GIG_CTRL, 0, w & np_gig_pkg::GIG_WRITE_MASK);
		give_verdict();
	end
endmodule : autoneg_next_page_rx_and_gig_control_bench
